// ==== src/link_test_defines.vh ====
// Constants of the serial link test pattern generator: register offsets,
// field positions, reset values, pattern codes and seeds.
// Assumes inclusion by bare name from the design files under src/.
`ifndef LINK_TEST_DEFINES_VH
`define LINK_TEST_DEFINES_VH

// ************************************************************
// Register offsets (byte wide registers)
// ************************************************************
`define ADDR_SOFT_RESET   12'h000
`define ADDR_USER_1_LSB   12'h551
`define ADDR_USER_1_MSB   12'h552
`define ADDR_USER_2_LSB   12'h553
`define ADDR_USER_2_MSB   12'h554
`define ADDR_USER_3_LSB   12'h555
`define ADDR_USER_3_MSB   12'h556
`define ADDR_USER_4_LSB   12'h557
`define ADDR_USER_4_MSB   12'h558
`define ADDR_LINK_CTRL    12'h572
`define ADDR_IF_TEST      12'h573
`define ADDR_DLL_TEST     12'h574
`define ADDR_STATUS       12'h579

// ************************************************************
// Field positions and values
// ************************************************************
`define SOFT_RESET_VALUE  8'h81
`define IF_MODE_MSB       3
`define IF_MODE_LSB       0
`define IF_POINT_MSB      5
`define IF_POINT_LSB      4
`define DLL_MODE_MSB      2
`define DLL_MODE_LSB      0
`define SYNC_IGNORE_BIT   6
`define LINK_CTRL_RESET   8'h00
`define IF_TEST_RESET     8'h00
`define DLL_TEST_RESET    8'h00

// ************************************************************
// Pattern codes and insertion points
// ************************************************************
`define PAT_OFF           4'h0
`define PAT_CHECKER       4'h1
`define PAT_TOGGLE        4'h2
`define PAT_PRBS_TWENTYTHREE_BIT          4'h4
`define PAT_PN9           4'h6
`define PAT_RAMP          4'h8
`define PAT_USER_REPEAT   4'he
`define PAT_USER_SINGLE   4'hf
`define POINT_SAMPLE      2'h0
`define POINT_PHY10       2'h1
`define POINT_SCRAM8      2'h2
`define STEP_SAMPLE       5'h10
`define STEP_PHY10        5'h0a
`define STEP_SCRAM8       5'h08
`define WORD_CHECKER_A    16'h5555
`define WORD_CHECKER_B    16'haaaa
`define WORD_TOGGLE_A     16'h0000
`define WORD_TOGGLE_B     16'hffff
`define SEED_PN9          9'h092
`define SEED_PRBS_TWENTYTHREE_BIT         23'h00_3aff

`endif

// ==== src/pattern_buffer.v ====
// Two-entry buffer with valid and ready on both sides.
// Assumes one clock, an active-low reset released in step with the clock
// and a clock enable.
`timescale 1ns/1ns
`default_nettype none
module pattern_buffer #(
    parameter WIDTH = 16
) (
    input  wire             clk,
    input  wire             rst_n,
    input  wire             ce,
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    output wire             out_valid,
    input  wire             out_ready,
    output reg  [WIDTH-1:0] out_data
);
    // ************************************************************
    // Storage
    // ************************************************************
    reg [WIDTH-1:0] spare;
    reg [1:0]       count;
    wire            push;
    wire            pop;

    // Ready depends on fill only, so a stall never loses a word.
    assign in_ready  = (count != 2'd2);
    assign out_valid = (count != 2'd0);
    assign push      = ce & in_valid & in_ready;
    assign pop       = ce & out_valid & out_ready;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count    <= 2'd0;
            spare    <= {WIDTH{1'b0}};
            out_data <= {WIDTH{1'b0}};
        end else if (ce) begin
            case ({push, pop})
                2'b10: begin
                    if (count == 2'd0)
                        out_data <= in_data;
                    else
                        spare <= in_data;
                    count <= count + 2'd1;
                end
                2'b01: begin
                    out_data <= spare;
                    count    <= count - 2'd1;
                end
                2'b11: begin
                    if (count == 2'd1)
                        out_data <= in_data;
                    else begin
                        out_data <= spare;
                        spare    <= in_data;
                    end
                end
                default: begin
                    count <= count;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// ==== src/link_test_pattern_gen.v ====
// Test pattern generator in the transmit path of the serial output link.
// Assumes a register master on a plain strobe port and a link layer that
// takes pattern words through a valid and ready handshake.
`timescale 1ns/1ns
`default_nettype none
`include "link_test_defines.vh"
module link_test_pattern_gen (
    input  wire        clk,
    input  wire        rstn,
    input  wire        ce,
    input  wire [11:0] reg_addr,
    input  wire [7:0]  reg_wdata,
    input  wire        reg_write,
    input  wire        reg_read,
    output reg  [7:0]  reg_rdata,
    input  wire        link_sync_request_in,
    output wire        sync_request_effective,
    output wire [2:0]  dll_test_mode,
    output wire        pattern_enable,
    output wire        pattern_valid,
    input  wire        pattern_ready,
    output wire [15:0] pattern_word,
    output wire [63:0] pattern_frame
);
    // ************************************************************
    // Reset release
    // ************************************************************
    reg rst_meta;
    reg rst_n;
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // ************************************************************
    // Registers
    // ************************************************************
    reg [15:0] user_word_one;
    reg [15:0] user_word_two;
    reg [15:0] user_word_three;
    reg [15:0] user_word_four;
    reg [7:0]  link_ctrl;
    reg [7:0]  if_test;
    reg [7:0]  dll_test;
    reg        restart;
    reg        single_done;
    wire [3:0] mode;
    wire [1:0] point;
    wire       wr;

    assign wr    = ce & reg_write;
    assign mode  = if_test[`IF_MODE_MSB:`IF_MODE_LSB];
    assign point = if_test[`IF_POINT_MSB:`IF_POINT_LSB];
    assign dll_test_mode = dll_test[`DLL_MODE_MSB:`DLL_MODE_LSB];
    // The link relies on software to set this bit during link tests.
    assign sync_request_effective =
        link_sync_request_in & ~link_ctrl[`SYNC_IGNORE_BIT];
    assign pattern_enable = (mode != `PAT_OFF);

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            user_word_one   <= 16'h0000;
            user_word_two   <= 16'h0000;
            user_word_three <= 16'h0000;
            user_word_four  <= 16'h0000;
            link_ctrl       <= `LINK_CTRL_RESET;
            if_test         <= `IF_TEST_RESET;
            dll_test        <= `DLL_TEST_RESET;
            restart         <= 1'b0;
        end else if (ce) begin
            // A soft reset or a new test setting restarts every sequence.
            restart <= wr & ((reg_addr == `ADDR_IF_TEST) |
                ((reg_addr == `ADDR_SOFT_RESET) &
                 (reg_wdata == `SOFT_RESET_VALUE)));
            if (wr) begin
                case (reg_addr)
                    `ADDR_USER_1_LSB: user_word_one[7:0]    <= reg_wdata;
                    `ADDR_USER_1_MSB: user_word_one[15:8]   <= reg_wdata;
                    `ADDR_USER_2_LSB: user_word_two[7:0]    <= reg_wdata;
                    `ADDR_USER_2_MSB: user_word_two[15:8]   <= reg_wdata;
                    `ADDR_USER_3_LSB: user_word_three[7:0]  <= reg_wdata;
                    `ADDR_USER_3_MSB: user_word_three[15:8] <= reg_wdata;
                    `ADDR_USER_4_LSB: user_word_four[7:0]   <= reg_wdata;
                    `ADDR_USER_4_MSB: user_word_four[15:8]  <= reg_wdata;
                    `ADDR_LINK_CTRL:  link_ctrl <= reg_wdata;
                    `ADDR_IF_TEST:    if_test   <= reg_wdata;
                    `ADDR_DLL_TEST:   dll_test  <= reg_wdata;
                    default:          link_ctrl <= link_ctrl;
                endcase
            end
        end
    end

    // The soft reset address is not decoded for reads, so it reads back as zero.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (ce) begin
            if (reg_read) begin
                case (reg_addr)
                    `ADDR_USER_1_LSB: reg_rdata <= user_word_one[7:0];
                    `ADDR_USER_1_MSB: reg_rdata <= user_word_one[15:8];
                    `ADDR_USER_2_LSB: reg_rdata <= user_word_two[7:0];
                    `ADDR_USER_2_MSB: reg_rdata <= user_word_two[15:8];
                    `ADDR_USER_3_LSB: reg_rdata <= user_word_three[7:0];
                    `ADDR_USER_3_MSB: reg_rdata <= user_word_three[15:8];
                    `ADDR_USER_4_LSB: reg_rdata <= user_word_four[7:0];
                    `ADDR_USER_4_MSB: reg_rdata <= user_word_four[15:8];
                    `ADDR_LINK_CTRL:  reg_rdata <= link_ctrl;
                    `ADDR_IF_TEST:    reg_rdata <= if_test;
                    `ADDR_DLL_TEST:   reg_rdata <= dll_test;
                    `ADDR_STATUS:     reg_rdata <= {5'h00,
                        link_ctrl[`SYNC_IGNORE_BIT], single_done,
                        pattern_enable};
                    default:          reg_rdata <= 8'h00;
                endcase
            end else begin
                reg_rdata <= 8'h00;
            end
        end
    end

    // ************************************************************
    // Pseudo-random streams
    // ************************************************************
    // Both functions walk sixteen bits and stop at the step width, so
    // the stream does not depend on the insertion point.
    function [8:0] pn9_adv;
        input [8:0] s;
        input [4:0] n;
        integer     i;
        reg   [8:0] t;
        begin
            t = s;
            for (i = 0; i < 16; i = i + 1) begin
                if (i < n)
                    t = {t[7:0], t[8] ^ t[4]};
            end
            pn9_adv = t;
        end
    endfunction

    // The long stream leaves at the low end, so the seed loads as written.
    function [22:0] prbs_twentythree_bit_adv;
        input [22:0] s;
        input [4:0]  n;
        integer      i;
        reg   [22:0] t;
        begin
            t = s;
            for (i = 0; i < 16; i = i + 1) begin
                if (i < n)
                    t = {t[0] ^ t[5], t[22:1]};
            end
            prbs_twentythree_bit_adv = t;
        end
    endfunction

    reg  [8:0]  pn9;
    reg  [22:0] prbs_twentythree_bit;
    wire [15:0] pn9_bits;
    wire [15:0] prbs_twentythree_bit_bits;

    // Bit k of the word is the stream bit that leaves after 15-k shifts.
    genvar g;
    generate
        for (g = 0; g < 16; g = g + 1) begin : slice
            localparam [4:0] shifts = g;
            wire [8:0]  s9;
            wire [22:0] s23;
            assign s9  = pn9_adv(pn9, shifts);
            assign s23 = prbs_twentythree_bit_adv(prbs_twentythree_bit, shifts);
            assign pn9_bits[15-g]  = s9[8];
            assign prbs_twentythree_bit_bits[15-g] = s23[0];
        end
    endgenerate

    // ************************************************************
    // Pattern step
    // ************************************************************
    reg  [15:0] ramp;
    reg         phase;
    reg  [1:0]  user_index;
    reg  [4:0]  step_bits;
    reg  [3:0]  shift;
    reg  [15:0] aligned;
    wire [15:0] gen_word;
    wire        gen_ready;
    wire        step;

    always @* begin
        case (point)
            `POINT_PHY10: begin
                step_bits = `STEP_PHY10;
                shift     = 4'd6;
            end
            `POINT_SCRAM8: begin
                step_bits = `STEP_SCRAM8;
                shift     = 4'd8;
            end
            default: begin
                step_bits = `STEP_SAMPLE;
                shift     = 4'd0;
            end
        endcase
    end

    always @* begin
        case (mode)
            `PAT_CHECKER:
                aligned = phase ? `WORD_CHECKER_B : `WORD_CHECKER_A;
            `PAT_TOGGLE:
                aligned = phase ? `WORD_TOGGLE_B : `WORD_TOGGLE_A;
            `PAT_PN9:  aligned = pn9_bits;
            `PAT_PRBS_TWENTYTHREE_BIT: aligned = prbs_twentythree_bit_bits;
            `PAT_RAMP: aligned = ramp << shift;
            `PAT_USER_REPEAT, `PAT_USER_SINGLE: begin
                case (user_index)
                    2'd0:    aligned = user_word_one;
                    2'd1:    aligned = user_word_two;
                    2'd2:    aligned = user_word_three;
                    default: aligned = user_word_four;
                endcase
                if (single_done)
                    aligned = 16'h0000;
            end
            default: aligned = 16'h0000;
        endcase
    end

    // Narrow points keep the upper bits, right aligned on the port.
    assign gen_word = aligned >> shift;
    assign step     = ce & pattern_enable & gen_ready;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pn9         <= `SEED_PN9;
            prbs_twentythree_bit        <= `SEED_PRBS_TWENTYTHREE_BIT;
            ramp        <= 16'h0000;
            phase       <= 1'b0;
            user_index  <= 2'd0;
            single_done <= 1'b0;
        end else if (ce) begin
            if (restart) begin
                pn9         <= `SEED_PN9;
                prbs_twentythree_bit        <= `SEED_PRBS_TWENTYTHREE_BIT;
                ramp        <= 16'h0000;
                phase       <= 1'b0;
                user_index  <= 2'd0;
                single_done <= 1'b0;
            end else if (step) begin
                pn9        <= pn9_adv(pn9, step_bits);
                prbs_twentythree_bit       <= prbs_twentythree_bit_adv(prbs_twentythree_bit, step_bits);
                ramp       <= ramp + 16'h0001;
                phase      <= ~phase;
                user_index <= user_index + 2'd1;
                if (mode == `PAT_USER_SINGLE && user_index == 2'd3)
                    single_done <= 1'b1;
            end
        end
    end

    // ************************************************************
    // Output buffer
    // ************************************************************
    pattern_buffer #(
        .WIDTH (16)
    ) out_buffer (
        .clk       (clk),
        .rst_n     (rst_n),
        .ce        (ce),
        .in_valid  (pattern_enable & ~restart),
        .in_ready  (gen_ready),
        .in_data   (gen_word),
        .out_valid (pattern_valid),
        .out_ready (pattern_ready),
        .out_data  (pattern_word)
    );

    // Both converters and both samples of a frame carry the same word.
    assign pattern_frame = {4{pattern_word}};
endmodule
`default_nettype wire

// ==== testbench/link_rx_model.sv ====
// Model of the link receiver that takes pattern words from the generator.
// Assumes the generator clock; the bench picks the pacing and empties got.
`timescale 1ns/1ns
`default_nettype none
module link_rx_model (
    input  wire logic        clk,
    input  wire logic        ce,
    input  wire logic [1:0]  pace,
    input  wire logic        pattern_valid,
    input  wire logic [15:0] pattern_word,
    output var  logic        pattern_ready,
    output var  logic        link_sync_request_in
);
    logic [15:0] got[$];

    initial begin
        pattern_ready = 1'b0;
        link_sync_request_in = 1'b0;
    end

    // Pace 0 takes every word, 1 stalls at random, 2 refuses everything.
    // The sync request wanders at random, as a real receiver may do.
    always @(posedge clk) begin
        if (pattern_valid && pattern_ready && ce) begin
            got.push_back(pattern_word);
        end
        pattern_ready <= (pace == 2'h0) ||
            (pace == 2'h1 && $urandom_range(1) != 0);
        link_sync_request_in <= ($urandom_range(1) != 0);
    end
endmodule
`default_nettype wire

// ==== testbench/link_test_pattern_gen_sva.sv ====
// Checker of the pattern generator, watching only the top module's ports.
// Assumes one clock and register writes made only with legal field values.
`timescale 1ns/1ns
`default_nettype none
`include "link_test_defines.vh"
module link_test_pattern_gen_sva (
    input wire logic        clk,
    input wire logic        rstn,
    input wire logic        ce,
    input wire logic [11:0] reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        reg_write,
    input wire logic        reg_read,
    input wire logic [7:0]  reg_rdata,
    input wire logic        link_sync_request_in,
    input wire logic        sync_request_effective,
    input wire logic [2:0]  dll_test_mode,
    input wire logic        pattern_enable,
    input wire logic        pattern_valid,
    input wire logic        pattern_ready,
    input wire logic [15:0] pattern_word,
    input wire logic [63:0] pattern_frame
);
    // ****************************************************************
    // Shadow copies of the control registers
    // ****************************************************************
    logic [7:0] link_ctrl;
    logic [7:0] if_test;
    logic [7:0] dll_test;

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            link_ctrl <= `LINK_CTRL_RESET;
            if_test <= `IF_TEST_RESET;
            dll_test <= `DLL_TEST_RESET;
        end else if (ce && reg_write) begin
            case (reg_addr)
                `ADDR_LINK_CTRL: link_ctrl <= reg_wdata;
                `ADDR_IF_TEST: if_test <= reg_wdata;
                `ADDR_DLL_TEST: dll_test <= reg_wdata;
                default: ;
            endcase
        end
    end

    // ****************************************************************
    // Properties
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    sequence s_rd_if; ce && reg_read && reg_addr == `ADDR_IF_TEST; endsequence
    sequence s_rd_dll; ce && reg_read && reg_addr == `ADDR_DLL_TEST; endsequence
    sequence s_stalled; pattern_valid && !(pattern_ready && ce); endsequence

    property p_sync_ignore;
        sync_request_effective ==
            (link_sync_request_in && !link_ctrl[`SYNC_IGNORE_BIT]);
    endproperty
    property p_dll_mode; dll_test_mode == dll_test[2:0]; endproperty
    property p_enable; pattern_enable == (if_test[3:0] != 4'h0); endproperty
    property p_frame; pattern_frame == {4{pattern_word}}; endproperty
    property p_hold;
        s_stalled |=> pattern_valid && $stable(pattern_word);
    endproperty
    property p_rdata_idle; ce && !reg_read |=> reg_rdata == 8'h00; endproperty
    property p_read_if; s_rd_if |=> reg_rdata == $past(if_test); endproperty
    property p_read_dll; s_rd_dll |=> reg_rdata == $past(dll_test); endproperty
    property p_freeze;
        !ce |=> $stable(pattern_valid) && $stable(pattern_word) &&
            $stable(reg_rdata);
    endproperty

    a_sync_ignore: assert property (p_sync_ignore)
        else $error("sync not masked");
    a_dll_mode: assert property (p_dll_mode)
        else $error("link test mode wrong");
    a_enable: assert property (p_enable)
        else $error("enable wrong");
    a_frame: assert property (p_frame)
        else $error("frame not four copies");
    a_hold: assert property (p_hold)
        else $error("word lost in stall");
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("rdata not idle");
    a_read_if: assert property (p_read_if)
        else $error("test reg read wrong");
    a_read_dll: assert property (p_read_dll)
        else $error("link reg read wrong");
    a_freeze: assert property (p_freeze)
        else $error("moved with ce low");
endmodule

bind link_test_pattern_gen link_test_pattern_gen_sva link_test_pattern_gen_sva_i (
    .clk(clk), .rstn(rstn), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .link_sync_request_in(link_sync_request_in),
    .sync_request_effective(sync_request_effective),
    .dll_test_mode(dll_test_mode), .pattern_enable(pattern_enable),
    .pattern_valid(pattern_valid), .pattern_ready(pattern_ready),
    .pattern_word(pattern_word), .pattern_frame(pattern_frame));
`default_nettype wire

// ==== testbench/tb_link_test_pattern_gen.sv ====
// Self-checking bench of the pattern generator with a random link receiver.
// Assumes the design header on the include path and the receiver model.
`timescale 1ns/1ns
`default_nettype none
`include "link_test_defines.vh"
module tb_link_test_pattern_gen;
    logic        clk, rstn, ce, reg_write, reg_read, pattern_enable;
    logic        link_sync_request_in, sync_request_effective;
    logic        pattern_valid, pattern_ready;
    logic [11:0] reg_addr;
    logic [7:0]  reg_wdata, reg_rdata;
    logic [2:0]  dll_test_mode;
    logic [15:0] pattern_word;
    logic [63:0] pattern_frame;
    logic [1:0]  pace;
    logic [15:0] user [4];
    logic [3:0]  modes [7] = '{4'h1, 4'h2, 4'h4, 4'h6, 4'h8, 4'he, 4'hf};
    int          fails, comparisons;
    // The known stream heads, sliced at each insertion width.
    localparam logic [79:0] pn9_bits = 80'h496f_c9a9_980c_651a_5fd1;
    localparam logic [79:0] prbs_twentythree_bit_bits = 80'hff5c_0029_b80a_3d72_9b26;

    link_test_pattern_gen link_test_pattern_gen_i (.clk(clk), .rstn(rstn),
        .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .link_sync_request_in(link_sync_request_in),
        .sync_request_effective(sync_request_effective),
        .dll_test_mode(dll_test_mode), .pattern_enable(pattern_enable),
        .pattern_valid(pattern_valid), .pattern_ready(pattern_ready),
        .pattern_word(pattern_word), .pattern_frame(pattern_frame));
    link_rx_model rx (.clk(clk), .ce(ce), .pace(pace),
        .pattern_valid(pattern_valid), .pattern_word(pattern_word),
        .pattern_ready(pattern_ready),
        .link_sync_request_in(link_sync_request_in));

    // ****************************************************************
    // Expectations and checks
    // ****************************************************************
    function automatic logic [15:0] expect_word(input logic [7:0] cfg,
                                                input int idx);
        int          w;
        logic [15:0] full;
        w = (cfg[5:4] == `POINT_PHY10) ? 10 :
            (cfg[5:4] == `POINT_SCRAM8) ? 8 : 16;
        case (cfg[3:0])
            `PAT_CHECKER: full = idx[0] ? `WORD_CHECKER_B : `WORD_CHECKER_A;
            `PAT_TOGGLE: full = idx[0] ? `WORD_TOGGLE_B : `WORD_TOGGLE_A;
            `PAT_PN9: full = pn9_bits[79 - idx * w -: 16];
            `PAT_PRBS_TWENTYTHREE_BIT: full = prbs_twentythree_bit_bits[79 - idx * w -: 16];
            `PAT_RAMP: full = 16'(idx << (16 - w));
            `PAT_USER_REPEAT: full = user[idx % 4];
            default: full = (idx < 4) ? user[idx] : 16'h0000;
        endcase
        return full >> (16 - w);
    endfunction

    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t word %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t value %h expected %h", $time, got, exp);
        end
    endtask

    task automatic conclude();
        if (fails == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ****************************************************************
    // Bus cycles and stream runs
    // ****************************************************************
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_read <= 1'b0;
        #1;
        chk_reg(reg_rdata, exp);
    endtask

    // Old words drain while ready is high, so only words of the new
    // setting are kept; a full stall then fills the buffer.
    task automatic run(input logic [11:0] a, input logic [7:0] d,
                       input logic [7:0] cfg);
        int n;
        wr(a, d);
        repeat (2) @(posedge clk);
        #1;
        rx.got.delete();
        pace = 2'h2;
        repeat (8) @(posedge clk);
        pace <= 2'h1;
        for (n = 0; n < 400 && rx.got.size() < 5; n++) begin
            @(posedge clk);
            ce <= ($urandom_range(7) != 0);
        end
        @(posedge clk);
        ce <= 1'b1;
        pace <= 2'h0;
        if (rx.got.size() < 5) begin
            fails++;
            $display("[ERR] %0t stream stalled", $time);
            conclude();
        end
        for (n = 0; n < 5; n++) begin
            chk_word(rx.got[n], expect_word(cfg, n));
        end
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        rstn = 1'b0;
        ce = 1'b1;
        {reg_write, reg_read, reg_addr, reg_wdata, pace} = '0;
        fails = 0;
        comparisons = 0;
        void'($urandom(18));
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        rd(`ADDR_LINK_CTRL, `LINK_CTRL_RESET);
        rd(`ADDR_IF_TEST, `IF_TEST_RESET);
        rd(12'h7ff, 8'h00);
        for (int i = 0; i < 8; i++) begin
            wr(`ADDR_DLL_TEST, 8'(i));
            #1;
            chk_reg({5'h00, dll_test_mode}, 8'(i));
            rd(`ADDR_DLL_TEST, 8'(i));
        end
        wr(`ADDR_LINK_CTRL, 8'hc0);
        repeat (6) begin
            @(posedge clk);
            #1;
            chk_reg({7'h00, sync_request_effective}, 8'h00);
        end
        rd(`ADDR_LINK_CTRL, 8'hc0);
        wr(`ADDR_LINK_CTRL, 8'h00);
        for (int p = 0; p < 3; p++) begin
            for (int k = 0; k < 4; k++) begin
                user[k] = (p == 0 && k == 0) ? 16'hffff : 16'($urandom);
                wr(12'(`ADDR_USER_1_LSB + 2 * k), user[k][7:0]);
                wr(12'(`ADDR_USER_1_MSB + 2 * k), user[k][15:8]);
                rd(12'(`ADDR_USER_1_MSB + 2 * k), user[k][15:8]);
            end
            for (int m = 0; m < 7; m++) begin
                run(`ADDR_IF_TEST, {2'b00, 2'(p), modes[m]},
                    {2'b00, 2'(p), modes[m]});
                rd(`ADDR_IF_TEST, {2'b00, 2'(p), modes[m]});
                rd(`ADDR_STATUS, {6'h00, modes[m] == 4'hf, 1'b1});
                chk_reg({7'h00, pattern_enable}, 8'h01);
            end
        end
        run(`ADDR_IF_TEST, 8'h28, 8'h28);
        run(`ADDR_SOFT_RESET, `SOFT_RESET_VALUE, 8'h28);
        wr(`ADDR_IF_TEST, 8'h00);
        wr(`ADDR_SOFT_RESET, `SOFT_RESET_VALUE);
        #1;
        chk_reg({7'h00, pattern_enable}, 8'h00);
        conclude();
    end
endmodule
`default_nettype wire
